// *** core/rssa_pkg.sv ***
`default_nettype none
package rssa_pkg;

   localparam int          DATA_W         = 8;
   localparam int          APB_ADDR_W     = 8;
   localparam int          APB_DATA_W     = 32;
   localparam int          FILE_ADDR_W    = 7;

   // register byte offsets
   localparam logic [7:0]  ACC_OFS        = 8'h00;
   localparam logic [7:0]  STATUS_OFS     = 8'h04;
   localparam logic [7:0]  SLEEP_OFS      = 8'h08;

   // status field positions, and the wake bit of the sleep register
   localparam int          ROLLOVER_POS   = 0;
   localparam int          HALF_POS       = 1;
   localparam int          ZERO_POS       = 2;
   localparam int          SLEEP_N_POS    = 3;
   localparam int          EXPIRY_N_POS   = 4;
   localparam int          WAKE_POS       = 0;

   // values after reset
   localparam logic [7:0]  ACC_RST        = 8'h00;
   localparam logic        ROLLOVER_RST   = 1'b0;
   localparam logic        HALF_RST       = 1'b0;
   localparam logic        ZERO_RST       = 1'b0;
   localparam logic        SLEEP_N_RST    = 1'b1;
   localparam logic        EXPIRY_N_RST   = 1'b1;

   localparam logic        DEST_ACC       = 1'b0;
   localparam logic [7:0]  ZERO_BYTE      = 8'h00;

   typedef enum logic [2:0] {
      OP_IDLE                          = 3'h0,
      OP_ROTATE_RIGHT_THROUGH_ROLLOVER = 3'h1,
      OP_ROTATE_LEFT_THROUGH_ROLLOVER  = 3'h2,
      OP_SLEEP_ENTRY                   = 3'h3,
      OP_LITERAL_MINUS_ACCUMULATOR     = 3'h4,
      OP_FILE_MINUS_ACCUMULATOR        = 3'h5,
      OP_SUBTRACT_WITH_BORROW_OP       = 3'h6,
      OP_NIBBLE_EXCHANGE_OP            = 3'h7
   } rssa_op_t;

   typedef enum logic {
      SLP_AWAKE  = 1'b0,
      SLP_ASLEEP = 1'b1
   } rssa_sleep_t;

endpackage : rssa_pkg
`default_nettype wire

// *** core/rssa_sub_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module rssa_sub_unit
   import rssa_pkg::*;
(
   input  wire logic [7:0] minuend,    // left operand
   input  wire logic [7:0] subtrahend, // right operand
   input  wire logic       borrowIn,   // extra borrow, high subtracts one more
   output logic      [7:0] diff,       // 8-bit difference
   output logic            rollover,   // high when no borrow out of bit 7
   output logic            halfBorrow, // high when no borrow out of bit 3
   output logic            isZero      // difference is zero
);
   logic [8:0] full;
   logic [4:0] low;

   always_comb begin
      full       = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
      low        = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
      diff       = full[7:0];
      rollover   = ~full[8];
      halfBorrow = ~low[4];
      isZero     = (full[7:0] == ZERO_BYTE);
   end
endmodule : rssa_sub_unit
`default_nettype wire

// *** core/rssa_alu.sv ***
// Notes on behaviour
// - rotate right: bit0 to rollover, rollover to bit7
// - destination bit 0 selects accumulator, 1 file
// - sleep enters sleep, clears watchdog and prescaler
// - sleep sets expiry flag, clears sleep flag
// - literal minus accumulator into accumulator
// - rollover, half borrow from literal comparison
// - file minus accumulator to selected destination
// - rollover, half borrow from file comparison
// - file minus accumulator minus inverted rollover
// - nibble swap, no flag changes
// - rotate left: bit7 to rollover, rollover to bit0
`timescale 1ns/100ps
`default_nettype none
module rssa_alu
   import rssa_pkg::*;
(
   input  wire logic                   clk,             // core clock
   input  wire logic                   rst,             // sync reset, active high
   input  wire logic                   psel,            // apb select
   input  wire logic                   penable,         // apb access phase
   input  wire logic                   pwrite,          // apb direction
   input  wire logic [APB_ADDR_W-1:0]  paddr,           // apb byte address
   input  wire logic [APB_DATA_W-1:0]  pwdata,          // apb write data
   output logic      [APB_DATA_W-1:0]  prdata,          // apb read data
   output logic                        pready,          // apb ready
   output logic                        pslverr,         // apb error, unmapped address
   input  wire logic                   opValid,         // decoded instruction valid
   input  wire rssa_op_t               opCode,          // decoded operation
   input  wire logic [FILE_ADDR_W-1:0] fileAddr,        // file register address
   input  wire logic                   destSel,         // 0 accumulator, 1 file
   input  wire logic [7:0]             literal,         // 8-bit literal operand
   input  wire logic [7:0]             fileOperand,     // contents of addressed file
   output logic                        fileWrEn,        // file write strobe
   output logic      [FILE_ADDR_W-1:0] fileWrAddr,      // file write address
   output logic      [7:0]             resultData,      // last result
   output logic      [7:0]             accOut,          // accumulator
   output logic                        rolloverOut,     // rollover flag
   output logic                        halfBorrowOut,   // half borrow flag
   output logic                        zeroOut,         // result-null flag
   output logic                        expiryFlagN,     // watchdog expiry flag, active low
   output logic                        sleepEntryFlagN, // sleep entry flag, active low
   output logic                        sleepState,      // core asleep
   output logic                        watchdogClear    // clears watchdog and prescaler
);
   logic [7:0]  acc_q;
   logic        rollover_q;
   logic        half_q;
   logic        zero_q;
   logic        expiryN_q;
   logic        sleepN_q;
   rssa_sleep_t sleep_q;
   logic        fileWrEn_q;
   logic [6:0]  fileWrAddr_q;
   logic [7:0]  result_q;
   logic        wdClear_q;

   logic        opGo;
   logic        apbWr;
   logic        isSub;
   logic [7:0]  subA;
   logic        subBorrow;
   logic [7:0]  subDiff;
   logic        subRoll;
   logic        subHalf;
   logic        subZero;
   logic [7:0]  result_d;
   logic        roll_d;
   logic        toAcc;
   logic        toFile;

   function automatic logic regHit(input logic [APB_ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
      regHit = (a == ofs);
   endfunction : regHit

   // instructions are refused while asleep
   assign opGo      = opValid && (sleep_q == SLP_AWAKE) && (opCode != OP_IDLE);
   assign apbWr     = psel && penable && pwrite;
   assign isSub     = (opCode == OP_LITERAL_MINUS_ACCUMULATOR) ||
                      (opCode == OP_FILE_MINUS_ACCUMULATOR) ||
                      (opCode == OP_SUBTRACT_WITH_BORROW_OP);
   assign subA      = (opCode == OP_LITERAL_MINUS_ACCUMULATOR) ? literal : fileOperand;
   assign subBorrow = (opCode == OP_SUBTRACT_WITH_BORROW_OP) ? ~rollover_q : 1'b0;

   rssa_sub_unit u_sub (
      .minuend    (subA),
      .subtrahend (acc_q),
      .borrowIn   (subBorrow),
      .diff       (subDiff),
      .rollover   (subRoll),
      .halfBorrow (subHalf),
      .isZero     (subZero)
   );

   always_comb begin
      result_d = fileOperand;
      roll_d   = rollover_q;
      case (opCode)
         OP_ROTATE_RIGHT_THROUGH_ROLLOVER: begin
            result_d = {rollover_q, fileOperand[7:1]};
            roll_d   = fileOperand[0];
         end
         OP_ROTATE_LEFT_THROUGH_ROLLOVER: begin
            result_d = {fileOperand[6:0], rollover_q};
            roll_d   = fileOperand[7];
         end
         OP_LITERAL_MINUS_ACCUMULATOR,
         OP_FILE_MINUS_ACCUMULATOR,
         OP_SUBTRACT_WITH_BORROW_OP: begin
            result_d = subDiff;
            roll_d   = subRoll;
         end
         OP_NIBBLE_EXCHANGE_OP: begin
            result_d = {fileOperand[3:0], fileOperand[7:4]};
         end
         default: begin
            result_d = fileOperand;
            roll_d   = rollover_q;
         end
      endcase
   end

   // literal subtract always lands in the accumulator
   always_comb begin
      toAcc  = 1'b0;
      toFile = 1'b0;
      if (opGo && opCode != OP_SLEEP_ENTRY) begin
         if (opCode == OP_LITERAL_MINUS_ACCUMULATOR) begin
            toAcc = 1'b1;
         end else if (destSel == DEST_ACC) begin
            toAcc = 1'b1;
         end else begin
            toFile = 1'b1;
         end
      end
   end

   // accumulator: instruction result wins over software write
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q <= ACC_RST;
      end else if (toAcc) begin
         acc_q <= result_d;
      end else if (apbWr && regHit(paddr, ACC_OFS)) begin
         acc_q <= pwdata[7:0];
      end
   end

   // arithmetic flags
   always_ff @(posedge clk) begin
      if (rst) begin
         rollover_q <= ROLLOVER_RST;
         half_q     <= HALF_RST;
         zero_q     <= ZERO_RST;
      end else if (opGo && opCode != OP_SLEEP_ENTRY && opCode != OP_NIBBLE_EXCHANGE_OP) begin
         rollover_q <= roll_d;
         if (isSub) begin
            half_q <= subHalf;
            zero_q <= subZero;
         end
      end else if (apbWr && regHit(paddr, STATUS_OFS)) begin
         rollover_q <= pwdata[ROLLOVER_POS];
         half_q     <= pwdata[HALF_POS];
         zero_q     <= pwdata[ZERO_POS];
      end
   end

   // power flags
   always_ff @(posedge clk) begin
      if (rst) begin
         expiryN_q <= EXPIRY_N_RST;
         sleepN_q  <= SLEEP_N_RST;
      end else if (opGo && opCode == OP_SLEEP_ENTRY) begin
         expiryN_q <= 1'b1;
         sleepN_q  <= 1'b0;
      end else if (apbWr && regHit(paddr, STATUS_OFS)) begin
         expiryN_q <= pwdata[EXPIRY_N_POS];
         sleepN_q  <= pwdata[SLEEP_N_POS];
      end
   end

   // sleep state: software writes wake bit to leave
   always_ff @(posedge clk) begin
      if (rst) begin
         sleep_q <= SLP_AWAKE;
      end else begin
         case (sleep_q)
            SLP_AWAKE: begin
               if (opGo && opCode == OP_SLEEP_ENTRY) begin
                  sleep_q <= SLP_ASLEEP;
               end
            end
            SLP_ASLEEP: begin
               if (apbWr && regHit(paddr, SLEEP_OFS) && pwdata[WAKE_POS]) begin
                  sleep_q <= SLP_AWAKE;
               end
            end
            default: sleep_q <= SLP_AWAKE;
         endcase
      end
   end

   // registered result outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         fileWrEn_q   <= 1'b0;
         fileWrAddr_q <= '0;
         result_q     <= ZERO_BYTE;
         wdClear_q    <= 1'b0;
      end else begin
         fileWrEn_q <= toFile;
         wdClear_q  <= opGo && (opCode == OP_SLEEP_ENTRY);
         if (toAcc || toFile) begin
            result_q     <= result_d;
            fileWrAddr_q <= fileAddr;
         end
      end
   end

   always_comb begin
      prdata  = '0;
      pslverr = 1'b0;
      if (psel && penable) begin
         if (regHit(paddr, ACC_OFS)) begin
            prdata[7:0] = acc_q;
         end else if (regHit(paddr, STATUS_OFS)) begin
            prdata[ROLLOVER_POS] = rollover_q;
            prdata[HALF_POS]     = half_q;
            prdata[ZERO_POS]     = zero_q;
            prdata[SLEEP_N_POS]  = sleepN_q;
            prdata[EXPIRY_N_POS] = expiryN_q;
         end else if (regHit(paddr, SLEEP_OFS)) begin
            prdata[WAKE_POS] = (sleep_q == SLP_ASLEEP);
         end else begin
            pslverr = 1'b1;
         end
      end
   end

   assign pready          = 1'b1;
   assign fileWrEn        = fileWrEn_q;
   assign fileWrAddr      = fileWrAddr_q;
   assign resultData      = result_q;
   assign accOut          = acc_q;
   assign rolloverOut     = rollover_q;
   assign halfBorrowOut   = half_q;
   assign zeroOut         = zero_q;
   assign expiryFlagN     = expiryN_q;
   assign sleepEntryFlagN = sleepN_q;
   assign sleepState      = (sleep_q == SLP_ASLEEP);
   assign watchdogClear   = wdClear_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_rotate_right: assert property (
      opGo && opCode == OP_ROTATE_RIGHT_THROUGH_ROLLOVER |=>
         resultData == {$past(rollover_q), $past(fileOperand[7:1])} &&
         rolloverOut == $past(fileOperand[0]))
      else $error("rotate right result or rollover wrong");

   a_rotate_left: assert property (
      opGo && opCode == OP_ROTATE_LEFT_THROUGH_ROLLOVER |=>
         resultData == {$past(fileOperand[6:0]), $past(rollover_q)} &&
         rolloverOut == $past(fileOperand[7]))
      else $error("rotate left result or rollover wrong");

   a_dest_file: assert property (
      opGo && destSel && opCode != OP_SLEEP_ENTRY &&
      opCode != OP_LITERAL_MINUS_ACCUMULATOR && !apbWr |=>
         fileWrEn && fileWrAddr == $past(fileAddr) && $stable(accOut))
      else $error("file destination not honoured");

   a_dest_acc: assert property (
      opGo && !destSel && opCode != OP_SLEEP_ENTRY |=> !fileWrEn && accOut == resultData)
      else $error("accumulator destination not honoured");

   a_sleep_entry: assert property (
      opGo && opCode == OP_SLEEP_ENTRY |=> watchdogClear && sleepState ##1 !watchdogClear)
      else $error("sleep entry or watchdog clear wrong");

   a_sleep_flags: assert property (
      opGo && opCode == OP_SLEEP_ENTRY && !apbWr |=>
         expiryFlagN && !sleepEntryFlagN && $stable(rolloverOut) && $stable(zeroOut))
      else $error("sleep flags wrong");

   a_literal_sub: assert property (
      opGo && opCode == OP_LITERAL_MINUS_ACCUMULATOR |=>
         accOut == 8'($past(literal) - $past(acc_q)) && !fileWrEn)
      else $error("literal subtract result wrong");

   a_literal_flags: assert property (
      opGo && opCode == OP_LITERAL_MINUS_ACCUMULATOR |=>
         rolloverOut == ($past(acc_q) <= $past(literal)) &&
         halfBorrowOut == ($past(acc_q[3:0]) <= $past(literal[3:0])))
      else $error("literal subtract flags wrong");

   a_file_sub: assert property (
      opGo && opCode == OP_FILE_MINUS_ACCUMULATOR |=>
         resultData == 8'($past(fileOperand) - $past(acc_q)))
      else $error("file subtract result wrong");

   a_file_flags: assert property (
      opGo && opCode == OP_FILE_MINUS_ACCUMULATOR |=>
         rolloverOut == ($past(acc_q) <= $past(fileOperand)) &&
         halfBorrowOut == ($past(acc_q[3:0]) <= $past(fileOperand[3:0])))
      else $error("file subtract flags wrong");

   a_borrow_sub: assert property (
      opGo && opCode == OP_SUBTRACT_WITH_BORROW_OP |=>
         resultData == 8'($past(fileOperand) - $past(acc_q) - {7'h00, ~$past(rollover_q)}))
      else $error("borrow subtract result wrong");

   a_swap_nibbles: assert property (
      opGo && opCode == OP_NIBBLE_EXCHANGE_OP && !apbWr |=>
         resultData == {$past(fileOperand[3:0]), $past(fileOperand[7:4])} &&
         $stable(rolloverOut) && $stable(halfBorrowOut) && $stable(zeroOut))
      else $error("nibble swap wrong");

   a_zero_flag: assert property (
      opGo && isSub |=> zeroOut == (resultData == ZERO_BYTE))
      else $error("zero flag wrong");

endmodule : rssa_alu
`default_nettype wire

// *** sim/rssa_file_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rssa_file_model
   import rssa_pkg::*;
(
   input  wire logic                   clk,         // core clock
   input  wire logic [FILE_ADDR_W-1:0] fileAddr,    // read address
   input  wire logic                   fileWrEn,    // write strobe
   input  wire logic [FILE_ADDR_W-1:0] fileWrAddr,  // write address
   input  wire logic [7:0]             resultData,  // write data
   output logic      [7:0]             fileOperand  // addressed contents
);
   logic [7:0] mem [128];

   // contents are always valid, read in the same cycle
   assign fileOperand = mem[fileAddr];

   always @(posedge clk) begin
      if (fileWrEn) begin
         mem[fileWrAddr] <= resultData;
      end
   end
endmodule : rssa_file_model
`default_nettype wire

// *** sim/test_rotate_subtract_swap_alu.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_rotate_subtract_swap_alu;
   import rssa_pkg::*;
   typedef struct {logic [7:0] acc, res; logic c, hb, z, wr, slp; logic [6:0] a;} rssa_note_t;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, opValid = 0, destSel = 0;
   logic [7:0]  paddr = 0, literal = 0, fileOperand, resultData, accOut;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, fileWrEn, rolloverOut, halfBorrowOut, zeroOut;
   logic        expiryFlagN, sleepEntryFlagN, sleepState, watchdogClear;
   logic [6:0]  fileAddr = 0, fileWrAddr;
   rssa_op_t    opCode = OP_IDLE;
   int          errTotal = 0, checks = 0;
   rssa_note_t  q[$];
   logic [7:0]  accM = 0, resM = 0, fm [128];
   logic        cM = 0, hbM = 0, zM = 0;

   always #2.5 clk = ~clk;

   rssa_alu dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .opValid, .opCode, .fileAddr, .destSel, .literal, .fileOperand, .fileWrEn,
      .fileWrAddr, .resultData, .accOut, .rolloverOut, .halfBorrowOut, .zeroOut, .expiryFlagN,
      .sleepEntryFlagN, .sleepState, .watchdogClear);
   rssa_file_model part (.clk, .fileAddr, .fileWrEn, .fileWrAddr, .resultData, .fileOperand);

   task chk(input logic ok, input string m);
      checks++;
      if (!ok) begin
         errTotal++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   task wrap_up;
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) begin
         chk(0, "bus timeout");
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1, a, d, r, e);
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] x, input logic xe, input string m);
      logic [31:0] r;
      logic        e;
      apb(0, a, 32'h0, r, e);
      chk(r === x && e === xe, m);
   endtask : rd

   // expectation noted before the instruction is driven
   task op(input rssa_op_t o, input logic d, input logic [6:0] a, input logic [7:0] k);
      rssa_note_t n;
      logic [8:0] t;
      logic [4:0] h;
      logic [7:0] f, s;
      logic       b;
      f = fm[a];
      n.wr = 0; n.slp = 0; n.a = a;
      case (o)
         OP_ROTATE_RIGHT_THROUGH_ROLLOVER: begin resM = {cM, f[7:1]}; cM = f[0]; end
         OP_ROTATE_LEFT_THROUGH_ROLLOVER: begin resM = {f[6:0], cM}; cM = f[7]; end
         OP_NIBBLE_EXCHANGE_OP: resM = {f[3:0], f[7:4]};
         OP_SLEEP_ENTRY: n.slp = 1;
         default: begin
            s = (o == OP_LITERAL_MINUS_ACCUMULATOR) ? k : f;
            b = (o == OP_SUBTRACT_WITH_BORROW_OP) ? ~cM : 1'b0;
            t = {1'b0, s} - {1'b0, accM} - {8'h00, b};
            h = {1'b0, s[3:0]} - {1'b0, accM[3:0]} - {4'h0, b};
            resM = t[7:0]; cM = ~t[8]; hbM = ~h[4]; zM = (t[7:0] == 8'h00);
         end
      endcase
      if (o != OP_SLEEP_ENTRY) begin
         if (o == OP_LITERAL_MINUS_ACCUMULATOR || d == DEST_ACC) accM = resM;
         else begin fm[a] = resM; n.wr = 1; end
      end
      n.acc = accM; n.res = resM; n.c = cM; n.hb = hbM; n.z = zM;
      q.push_back(n);
      @(posedge clk);
      opValid <= 1; opCode <= o; destSel <= d; fileAddr <= a; literal <= k;
   endtask : op

   task idle;
      @(posedge clk);
      opValid <= 0;
   endtask : idle

   always @(posedge clk) begin
      rssa_note_t n;
      if (rst === 1'b0 && opValid === 1'b1 && opCode !== OP_IDLE && sleepState === 1'b0) begin
         #1;
         if (q.size() == 0) chk(0, "result without instruction");
         else begin
            n = q.pop_front();
            chk(accOut === n.acc, "accumulator");
            chk(resultData === n.res, "result");
            chk(rolloverOut === n.c && halfBorrowOut === n.hb && zeroOut === n.z, "flags");
            chk(fileWrEn === n.wr && (!n.wr || fileWrAddr === n.a), "file write");
            if (n.slp) chk(watchdogClear === 1'b1 && sleepState === 1'b1, "sleep entry");
            if (n.slp) chk(expiryFlagN === 1'b1 && sleepEntryFlagN === 1'b0, "sleep flags");
            if (!n.slp) chk(watchdogClear === 1'b0, "clear pulse");
         end
      end
   end

   initial begin
      logic [7:0] k;
      int         j;
      void'($urandom(85885));
      for (int i = 0; i < 128; i++) begin
         fm[i] = 8'($urandom);
         part.mem[i] = fm[i];
      end
      repeat (6) @(posedge clk);
      rst <= 0;
      rd(STATUS_OFS, 32'h18, 0, "status after reset");
      rd(ACC_OFS, 32'h0, 0, "acc after reset");
      rd(8'h0C, 32'h0, 1, "unmapped read");
      wr(8'h0C, 32'hFF);
      rd(ACC_OFS, 32'h0, 0, "unmapped write ignored");
      fm[5] = 8'hE6;
      part.mem[5] = 8'hE6;
      op(OP_ROTATE_LEFT_THROUGH_ROLLOVER, DEST_ACC, 7'h05, 8'h00);
      idle();
      for (int r = 0; r < 4; r++) begin
         k = 8'($urandom);
         wr(ACC_OFS, {24'h0, k});
         accM = k;
         k = 8'($urandom);
         wr(STATUS_OFS, {24'h0, 3'h0, 2'h3, k[2:0]});
         cM = k[0]; hbM = k[1]; zM = k[2];
         rd(STATUS_OFS, {27'h0, 2'h3, k[2:0]}, 0, "status write");
         for (int i = 0; i < 24; i++) begin
            j = i % 6;
            op(rssa_op_t'(j < 2 ? j + 1 : j + 2), 1'($urandom), 7'(r * 24 + i), 8'($urandom));
         end
         idle();
      end
      wr(ACC_OFS, 32'h3C);
      accM = 8'h3C;
      op(OP_LITERAL_MINUS_ACCUMULATOR, 1'b1, 7'h00, 8'h3C);
      op(OP_SLEEP_ENTRY, 1'b0, 7'h00, 8'h00);
      @(posedge clk);
      opCode <= OP_LITERAL_MINUS_ACCUMULATOR;
      literal <= 8'h55;
      repeat (2) @(posedge clk);
      opValid <= 0;
      @(posedge clk);
      chk(accOut === accM, "ignored while asleep");
      rd(STATUS_OFS, {27'h0, 2'b10, zM, hbM, cM}, 0, "status asleep");
      rd(SLEEP_OFS, 32'h1, 0, "asleep");
      wr(SLEEP_OFS, 32'h1);
      rd(SLEEP_OFS, 32'h0, 0, "awake");
      op(OP_NIBBLE_EXCHANGE_OP, 1'b1, 7'h64, 8'h00);
      idle();
      repeat (2) @(posedge clk);
      chk(q.size() == 0, "results missing");
      // second reset in mid-run, with state away from reset values
      wr(ACC_OFS, 32'hA5);
      @(posedge clk);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      rd(STATUS_OFS, 32'h18, 0, "status after second reset");
      rd(ACC_OFS, 32'h0, 0, "acc after second reset");
      chk(resultData === 8'h00 && fileWrEn === 1'b0 && sleepState === 1'b0, "outputs after reset");
      wrap_up();
   end
endmodule : test_rotate_subtract_swap_alu
`default_nettype wire
